// *** hw/tmcp_cfg.svh ***
// Register map, field positions and reset values of the capture timer.
// How it works
// - Source select set: input-1 edge flags A, no capture.
// - Source select set: both-edge input 0 blocks capture into A.
// - Restart mode: capture into B, then clear counter.
// - Edge select for input 0 at bits 5:4.
// - Input level valid after two equal count-clock samples.
// - Enable plus A-toggle inverts output every A+1 counts.
// - Square wave: counter clears on match with A.
// - PPG: output inverts on match A and match B.
// - Two-bit initial level field; 11 is ignored.
// - PPG period A+1 counts, duty B+1 counts.
// - Trigger clears counter; active at smaller, inactive larger.
// - Larger-first order handled; equal values not allowed.
// - Counter keeps running after pulse until mode 00.
// - Counter starts as soon as mode leaves 00.
// - Input-0 edge also restarts counter in one-shot.
// - External one-shot: input-0 edge clears and starts.
// - Overflow flag set on wrap from maximum.
// - Trigger bit self-clears and reads zero.
// - Capture at count tick, interrupt at next tick.
`ifndef TMCP_CFG_SVH
`define TMCP_CFG_SVH
`define TMCP_ADR_CNT 4'h0
`define TMCP_ADR_CRA 4'h1
`define TMCP_ADR_CRB 4'h2
`define TMCP_ADR_CCR 4'h3
`define TMCP_ADR_PRM 4'h4
`define TMCP_ADR_TMR 4'h5
`define TMCP_ADR_OCR 4'h6
`define TMCP_ADR_STS 4'h7
`define TMCP_CCR_A_CAP 0
`define TMCP_CCR_B_SRC 1
`define TMCP_CCR_B_CAP 2
`define TMCP_PRM_ES0 4
`define TMCP_PRM_ES1 6
`define TMCP_TMR_OVF 0
`define TMCP_TMR_OP 2
`define TMCP_OCR_OE 0
`define TMCP_OCR_TGA 1
`define TMCP_OCR_LVR 2
`define TMCP_OCR_LVS 3
`define TMCP_OCR_TGB 4
`define TMCP_OCR_OSE 5
`define TMCP_OCR_OST 6
`define TMCP_ES_FALL 2'h0
`define TMCP_ES_RISE 2'h1
`define TMCP_ES_BOTH 2'h3
`define TMCP_CR_RST 16'h0000
`define TMCP_PRM_RST 8'h00
`define TMCP_CNT_MAX 16'hFFFF
`endif

// *** hw/tmcp_pkg.sv ***
// Types shared by the capture timer.
package tmcp_pkg;
    typedef enum logic [1:0] {
        TMCP_STOP    = 2'b00,
        TMCP_RESTART = 2'b01,
        TMCP_FREE    = 2'b10,
        TMCP_CLRA    = 2'b11
    } tmcp_mode_e;
    typedef enum logic [1:0] {
        OS_IDLE = 2'b00,
        OS_WAIT = 2'b01,
        OS_ACT  = 2'b10
    } tmcp_os_e;
    typedef struct packed {
        logic rise;
        logic fall;
    } tmcp_edge_s;
    typedef logic [1:0] tmcp_lvl_t;
endpackage

// *** hw/tmcp_timer.sv ***
// Sixteen-bit timer with two capture/compare registers and pulse output.
`timescale 1ns/1ps
`include "tmcp_cfg.svh"
module tmcp_timer #(
    parameter int W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [3:0]        addr_i,
    input  wire logic [15:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [15:0]       rdata_o,
    input  wire logic              timer_input_0_i,
    input  wire logic              timer_input_1_i,
    output logic                   timer_output_pin_o,
    output logic                   match_a_irq_o,
    output logic                   match_b_irq_o,
    output tmcp_pkg::tmcp_lvl_t    in_level_o
);
    import tmcp_pkg::*;

    logic [W-1:0] main_counter_q, compare_reg_a_q, compare_reg_b_q;
    logic [2:0]   capcmp_control_reg_q;
    logic [7:0]   prescaler_mode_reg_q;
    logic [1:0]   op_mode_q;
    logic         overflow_flag_q;
    logic         oe_q, tga_q, tgb_q, ose_q, ost_q;
    logic [2:0]   pre_q;
    logic [1:0][2:0] sy_q;
    logic [1:0]   cln_q, smp_q, lvl_q;
    logic         out_q, pend_a_q, pend_b_q;
    tmcp_os_e     os_q, os_d;
    tmcp_edge_s   e0, e1;

    function automatic logic valid_edge(input logic [1:0] es, input tmcp_edge_s e);
        case (es)
            `TMCP_ES_FALL: valid_edge = e.fall;
            `TMCP_ES_RISE: valid_edge = e.rise;
            `TMCP_ES_BOTH: valid_edge = e.rise | e.fall;
            default:       valid_edge = 1'b0;
        endcase
    endfunction

    // Register decode.
    wire wr_cra = wr_i & (addr_i == `TMCP_ADR_CRA);
    wire wr_crb = wr_i & (addr_i == `TMCP_ADR_CRB);
    wire wr_ccr = wr_i & (addr_i == `TMCP_ADR_CCR);
    wire wr_prm = wr_i & (addr_i == `TMCP_ADR_PRM);
    wire wr_tmr = wr_i & (addr_i == `TMCP_ADR_TMR);
    wire wr_ocr = wr_i & (addr_i == `TMCP_ADR_OCR);

    wire tmcp_mode_e mode = tmcp_mode_e'(op_mode_q);
    wire run   = (mode != TMCP_STOP);
    wire [1:0] psel = prescaler_mode_reg_q[1:0];
    wire [2:0] pmask = (psel == 2'd0) ? 3'h0 : (psel == 2'd1) ? 3'h1 :
                       (psel == 2'd2) ? 3'h3 : 3'h7;
    wire tick = run & ((pre_q & pmask) == pmask);

    wire [1:0] es0 = prescaler_mode_reg_q[`TMCP_PRM_ES0+:2];
    wire [1:0] es1 = prescaler_mode_reg_q[`TMCP_PRM_ES1+:2];
    wire a_cap = capcmp_control_reg_q[`TMCP_CCR_A_CAP];
    wire b_src = capcmp_control_reg_q[`TMCP_CCR_B_SRC];
    wire b_cap = capcmp_control_reg_q[`TMCP_CCR_B_CAP];

    // A level change counts once two count-clock samples agree.
    wire [1:0] agree = ~(smp_q ^ cln_q) & {2{tick}};
    assign e0.rise = agree[0] & cln_q[0] & ~lvl_q[0];
    assign e0.fall = agree[0] & ~cln_q[0] & lvl_q[0];
    assign e1.rise = agree[1] & cln_q[1] & ~lvl_q[1];
    assign e1.fall = agree[1] & ~cln_q[1] & lvl_q[1];

    wire v0 = valid_edge(es0, e0);
    wire v1 = valid_edge(es1, e1);
    // Reverse edge of input 0 for capture into A; none when both edges.
    wire rev0 = (es0 == `TMCP_ES_FALL) ? e0.rise :
                (es0 == `TMCP_ES_RISE) ? e0.fall : 1'b0;

    wire cap_b = b_cap & v0;
    wire cap_a = a_cap & (b_src ? rev0 : v1);
    wire match_a = tick & ~a_cap & (main_counter_q == compare_reg_a_q);
    wire match_b = tick & ~b_cap & (main_counter_q == compare_reg_b_q);
    wire ev_a = match_a | cap_a | (b_src & v1);
    wire ev_b = match_b | cap_b;

    wire sw_trig = tick & ost_q & ose_q;
    wire ostart = sw_trig | (ose_q & v0);
    wire clr = ((mode == TMCP_RESTART) & v0) | ((mode == TMCP_CLRA) & match_a) | ostart;
    wire wrap = tick & ~clr & (main_counter_q == `TMCP_CNT_MAX);

    // One-shot edges: active at the smaller compare, inactive at the larger.
    wire b_first = compare_reg_b_q < compare_reg_a_q;
    wire hit_lo = b_first ? match_b : match_a;
    wire hit_hi = b_first ? match_a : match_b;

    always_comb begin
        os_d = os_q;
        case (os_q)
            OS_IDLE: if (ostart) begin
                os_d = OS_WAIT;
            end
            OS_WAIT: if (~ostart & hit_lo) begin
                os_d = OS_ACT;
            end
            OS_ACT: if (~ostart & hit_hi) begin
                os_d = OS_IDLE;
            end
            default: os_d = OS_IDLE;
        endcase
        if (!ose_q) begin
            os_d = OS_IDLE;
        end
    end

    wire lvs = wdata_i[`TMCP_OCR_LVS];
    wire lvr = wdata_i[`TMCP_OCR_LVR];
    wire set_lvl = wr_ocr & (lvs ^ lvr);
    wire toggle = ~ose_q & ((tga_q & match_a) ^ (tgb_q & match_b));
    wire out_d = set_lvl ? lvs :
                 (os_q == OS_WAIT && os_d == OS_ACT) ? 1'b1 :
                 (os_q == OS_ACT && os_d == OS_IDLE) ? 1'b0 :
                 out_q ^ toggle;

    wire [15:0] rmux =
        (addr_i == `TMCP_ADR_CNT) ? 16'(main_counter_q) :
        (addr_i == `TMCP_ADR_CRA) ? 16'(compare_reg_a_q) :
        (addr_i == `TMCP_ADR_CRB) ? 16'(compare_reg_b_q) :
        (addr_i == `TMCP_ADR_CCR) ? {13'h0000, capcmp_control_reg_q} :
        (addr_i == `TMCP_ADR_PRM) ? {8'h00, prescaler_mode_reg_q} :
        (addr_i == `TMCP_ADR_TMR) ? {12'h000, op_mode_q, 1'b0, overflow_flag_q} :
        (addr_i == `TMCP_ADR_OCR) ? {10'h000, ose_q, tgb_q, 2'b00, tga_q, oe_q} :
        (addr_i == `TMCP_ADR_STS) ? {12'h000, lvl_q, os_q} : 16'h0000;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sy_q  <= '0;
            cln_q <= 2'b00;
            smp_q <= 2'b00;
            lvl_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                sy_q[i] <= {sy_q[i][1:0], (i == 0) ? timer_input_0_i : timer_input_1_i};
                if (sy_q[i][1] == sy_q[i][2]) begin
                    cln_q[i] <= sy_q[i][2];
                end
                if (tick) begin
                    smp_q[i] <= cln_q[i];
                end
                if (agree[i]) begin
                    lvl_q[i] <= cln_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_q          <= 3'h0;
            main_counter_q <= '0;
        end else begin
            pre_q <= run ? pre_q + 3'h1 : 3'h0;
            if (!run) begin
                main_counter_q <= '0;
            end else if (tick) begin
                main_counter_q <= clr ? '0 : main_counter_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            compare_reg_a_q      <= `TMCP_CR_RST;
            compare_reg_b_q      <= `TMCP_CR_RST;
            capcmp_control_reg_q <= 3'h0;
            prescaler_mode_reg_q <= `TMCP_PRM_RST;
            op_mode_q            <= 2'h0;
            {oe_q, tga_q, tgb_q, ose_q} <= 4'h0;
        end else begin
            if (cap_a) begin
                compare_reg_a_q <= main_counter_q;
            end else if (wr_cra) begin
                compare_reg_a_q <= wdata_i[W-1:0];
            end
            if (cap_b) begin
                compare_reg_b_q <= main_counter_q;
            end else if (wr_crb) begin
                compare_reg_b_q <= wdata_i[W-1:0];
            end
            if (wr_ccr) begin
                capcmp_control_reg_q <= wdata_i[2:0];
            end
            if (wr_prm) begin
                prescaler_mode_reg_q <= wdata_i[7:0];
            end
            if (wr_tmr) begin
                op_mode_q <= wdata_i[`TMCP_TMR_OP+:2];
            end
            if (wr_ocr) begin
                oe_q  <= wdata_i[`TMCP_OCR_OE];
                tga_q <= wdata_i[`TMCP_OCR_TGA];
                tgb_q <= wdata_i[`TMCP_OCR_TGB];
                ose_q <= wdata_i[`TMCP_OCR_OSE];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overflow_flag_q    <= 1'b0;
            ost_q              <= 1'b0;
            os_q               <= OS_IDLE;
            out_q              <= 1'b0;
            pend_a_q           <= 1'b0;
            pend_b_q           <= 1'b0;
            match_a_irq_o      <= 1'b0;
            match_b_irq_o      <= 1'b0;
            timer_output_pin_o <= 1'b0;
            rdata_o            <= 16'h0000;
            in_level_o         <= 2'b00;
        end else begin
            if (wrap) begin
                overflow_flag_q <= 1'b1;
            end else if (wr_tmr && !wdata_i[`TMCP_TMR_OVF]) begin
                overflow_flag_q <= 1'b0;
            end
            if (wr_ocr && wdata_i[`TMCP_OCR_OST]) begin
                ost_q <= 1'b1;
            end else if (tick || !run) begin
                ost_q <= 1'b0;
            end
            os_q <= os_d;
            out_q <= out_d;
            if (!run) begin
                pend_a_q <= 1'b0;
                pend_b_q <= 1'b0;
            end else if (tick) begin
                pend_a_q <= ev_a;
                pend_b_q <= ev_b;
            end
            match_a_irq_o      <= tick & pend_a_q;
            match_b_irq_o      <= tick & pend_b_q;
            timer_output_pin_o <= oe_q & out_d;
            rdata_o            <= rd_i ? rmux : 16'h0000;
            in_level_o         <= lvl_q;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_ovf;
        wrap |=> overflow_flag_q;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag missed");

    property p_inc;
        tick && !clr && !wr_tmr |=> main_counter_q == $past(main_counter_q) + 1'b1;
    endproperty
    a_inc: assert property (p_inc) else $error("counter did not step");

    property p_restart;
        tick && mode == TMCP_RESTART && v0 && b_cap && !wr_tmr
            |=> main_counter_q == '0 && compare_reg_b_q == $past(main_counter_q);
    endproperty
    a_restart: assert property (p_restart) else $error("restart capture wrong");

    property p_clra;
        mode == TMCP_CLRA && match_a && !wr_tmr |=> main_counter_q == '0;
    endproperty
    a_clra: assert property (p_clra) else $error("no clear on match A");

    property p_src;
        b_src && !rev0 && !wr_cra |=> compare_reg_a_q == $past(compare_reg_a_q);
    endproperty
    a_src: assert property (p_src) else $error("A captured from input 1");

    property p_both;
        es0 == `TMCP_ES_BOTH && b_src && !wr_cra |=> $stable(compare_reg_a_q);
    endproperty
    a_both: assert property (p_both) else $error("A captured on both edges");

    property p_irq;
        cap_b |-> ##[1:9] match_b_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("capture interrupt late");

    property p_tog;
        toggle && !set_lvl |=> out_q != $past(out_q);
    endproperty
    a_tog: assert property (p_tog) else $error("output not inverted");

    property p_osoff;
        os_q == OS_ACT && hit_hi && !ostart && !set_lvl |=> !out_q && os_q == OS_IDLE;
    endproperty
    a_osoff: assert property (p_osoff) else $error("one-shot not ended");

    property p_sw;
        sw_trig && run && !wr_tmr |=> main_counter_q == '0 && os_q != OS_IDLE;
    endproperty
    a_sw: assert property (p_sw) else $error("trigger did not restart");

    property p_start;
        $rose(run) |-> ##[1:10] main_counter_q != '0;
    endproperty
    a_start: assert property (p_start) else $error("counter did not start");

    c_restart: cover property (tick && mode == TMCP_RESTART && v0 && b_cap);
    c_oneshot: cover property (os_q == OS_ACT ##1 os_q == OS_IDLE);
    c_ovf: cover property (wrap);
endmodule

// *** verification/tmcp_pin_src.sv ***
// Model of the external pulse sources wired to the two timer input pins.
`timescale 1ns/1ps
module tmcp_pin_src (
    input  wire logic clk_i,
    output logic      pin0_o,
    output logic      pin1_o
);
    initial begin
        pin0_o = 1'b0;
        pin1_o = 1'b0;
    end
    // Sets one pin after the next rising edge and keeps it for n cycles.
    task automatic drive(input int ch, input logic v, input int n);
        @(posedge clk_i);
        if (ch == 0) begin
            pin0_o <= v;
        end else begin
            pin1_o <= v;
        end
        repeat (n - 1) @(posedge clk_i);
    endtask
endmodule

// *** verification/tmcp_timer_tb_top.sv ***
// Self-checking testbench of the capture timer.
`timescale 1ns/1ps
`include "tmcp_cfg.svh"
`define CHK(g, e) begin \
    checked++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end
module tmcp_timer_tb_top;
    import tmcp_pkg::*;
    logic               clk;
    logic               rst_b;
    logic               wr;
    logic               rd;
    logic [3:0]         addr;
    logic [15:0]        wdata;
    logic [15:0]        rdata;
    logic [15:0]        d;
    logic [15:0]        d2;
    logic               pin;
    logic               irq_a;
    logic               irq_b;
    tmcp_lvl_t          lvl;
    logic               tin0;
    logic               tin1;
    logic [1:0]         es_list [3] = '{2'h1, 2'h0, 2'h3};
    int                 num_errors;
    int                 checked;
    int                 cyc;
    int                 na;
    int                 nb;
    int                 n1;
    int                 n2;
    int                 a;
    int                 b;
    int                 h;
    tmcp_timer DUT (
        .clk_i              (clk),
        .rst_b_i            (rst_b),
        .addr_i             (addr),
        .wdata_i            (wdata),
        .wr_i               (wr),
        .rd_i               (rd),
        .rdata_o            (rdata),
        .timer_input_0_i    (tin0),
        .timer_input_1_i    (tin1),
        .timer_output_pin_o (pin),
        .match_a_irq_o      (irq_a),
        .match_b_irq_o      (irq_b),
        .in_level_o         (lvl)
    );
    tmcp_pin_src src (
        .clk_i  (clk),
        .pin0_o (tin0),
        .pin1_o (tin1)
    );
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (irq_a === 1'b1) na++;
        if (irq_b === 1'b1) nb++;
        if (cyc == 80000) begin
            num_errors++;
            close_out();
        end
    end
    function automatic int cap_exp(input logic [1:0] es, input int hp);
        return ((es == 2'h3) ? hp : 2 * hp) - 1;
    endfunction
    function automatic int os_width(input int n, input int m);
        return (n > m) ? n - m : m - n;
    endfunction
    task automatic close_out();
        $display("Checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] ad, input logic [15:0] dv);
        @(posedge clk);
        addr  <= ad;
        wdata <= dv;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] ad, output logic [15:0] dv);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 dv = rdata;
    endtask
    task automatic wait_pin(output int n);
        logic v;
        v = pin;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pin === v && n < 1000);
    endtask
    task automatic oneshot(input bit ext, input int n, input int m);
        wr_reg(`TMCP_ADR_TMR, 16'h0000);
        wr_reg(`TMCP_ADR_CRA, 16'(m));
        wr_reg(`TMCP_ADR_CRB, 16'(n));
        wr_reg(`TMCP_ADR_CCR, 16'h0000);
        wr_reg(`TMCP_ADR_PRM, 16'h0010);
        wr_reg(`TMCP_ADR_OCR, 16'h0025);
        wr_reg(`TMCP_ADR_TMR, 16'h0008);
        if (ext) src.drive(0, 1'b1, 1);
        else wr_reg(`TMCP_ADR_OCR, 16'h0061);
        wait_pin(n1);
        wait_pin(n2);
        `CHK(n2, os_width(n, m))
        rd_reg(`TMCP_ADR_OCR, d);
        `CHK(d[6], 1'b0)
        rd_reg(`TMCP_ADR_CNT, d);
        rd_reg(`TMCP_ADR_CNT, d2);
        `CHK(d2 != d, 1'b1)
        if (ext) src.drive(0, 1'b0, 2);
    endtask
    initial begin
        rst_b = 1'b0;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 4'h0;
        wdata = 16'h0000;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        void'($urandom(96));
        for (int i = 0; i < 10; i++) begin
            rd_reg(4'(i), d);
            `CHK(d, 16'h0000)
        end
        wr_reg(`TMCP_ADR_TMR, 16'h0008);
        rd_reg(`TMCP_ADR_CNT, d);
        `CHK(d > 16'h0000 && d < 16'h0008, 1'b1)
        wr_reg(`TMCP_ADR_TMR, 16'h0000);
        wr_reg(`TMCP_ADR_OCR, 16'h0009);
        repeat (2) @(posedge clk);
        `CHK(pin, 1'b1)
        wr_reg(`TMCP_ADR_OCR, 16'h000D);
        repeat (2) @(posedge clk);
        `CHK(pin, 1'b1)
        wr_reg(`TMCP_ADR_OCR, 16'h0005);
        repeat (2) @(posedge clk);
        `CHK(pin, 1'b0)
        a = 2 + $urandom % 7;
        wr_reg(`TMCP_ADR_CRA, 16'(a));
        wr_reg(`TMCP_ADR_OCR, 16'h0003);
        wr_reg(`TMCP_ADR_TMR, 16'h000C);
        wait_pin(n1);
        n2 = na;
        wait_pin(n1);
        `CHK(n1, a + 1)
        wait_pin(n1);
        `CHK(n1, a + 1)
        `CHK(na - n2, 2)
        wr_reg(`TMCP_ADR_TMR, 16'h0000);
        b = 1 + $urandom % 5;
        a = b + 2 + $urandom % 6;
        wr_reg(`TMCP_ADR_CRA, 16'(a));
        wr_reg(`TMCP_ADR_CRB, 16'(b));
        wr_reg(`TMCP_ADR_OCR, 16'h0013);
        wr_reg(`TMCP_ADR_TMR, 16'h000C);
        wait_pin(n1);
        wait_pin(n1);
        wait_pin(n2);
        `CHK(n1 + n2, a + 1)
        `CHK(n1 == b + 1 || n2 == b + 1, 1'b1)
        foreach (es_list[i]) begin
            h = 4 + $urandom % 8;
            wr_reg(`TMCP_ADR_TMR, 16'h0000);
            wr_reg(`TMCP_ADR_CRA, 16'h1234);
            wr_reg(`TMCP_ADR_CCR, 16'h0007);
            wr_reg(`TMCP_ADR_PRM, {10'h000, es_list[i], 4'h0});
            wr_reg(`TMCP_ADR_TMR, 16'h0004);
            n2 = nb;
            repeat (4) src.drive(0, ~tin0, h);
            repeat (8) @(posedge clk);
            `CHK(nb - n2, (es_list[i] == 2'h3) ? 4 : 2)
            rd_reg(`TMCP_ADR_CRB, d);
            `CHK(d, 16'(cap_exp(es_list[i], h)))
            rd_reg(`TMCP_ADR_CRA, d);
            `CHK(d, (es_list[i] == 2'h3) ? 16'h1234 : 16'(h - 1))
        end
        wr_reg(`TMCP_ADR_TMR, 16'h0000);
        wr_reg(`TMCP_ADR_PRM, 16'h0010);
        wr_reg(`TMCP_ADR_TMR, 16'h0004);
        n2 = nb;
        src.drive(0, 1'b1, 1);
        src.drive(0, 1'b0, 12);
        `CHK(nb - n2, 0)
        wr_reg(`TMCP_ADR_TMR, 16'h0000);
        wr_reg(`TMCP_ADR_CCR, 16'h0003);
        wr_reg(`TMCP_ADR_PRM, 16'h0040);
        wr_reg(`TMCP_ADR_TMR, 16'h0008);
        n2 = na;
        src.drive(1, 1'b1, 12);
        `CHK(lvl, 2'b10)
        src.drive(1, 1'b0, 12);
        `CHK(na - n2, 1)
        rd_reg(`TMCP_ADR_CRA, d);
        `CHK(d, 16'h1234)
        b = 2 + $urandom % 10;
        a = b + 1 + $urandom % 10;
        oneshot(1'b0, b, a);
        oneshot(1'b0, a, b);
        oneshot(1'b1, b, a);
        wr_reg(`TMCP_ADR_TMR, 16'h0000);
        wr_reg(`TMCP_ADR_TMR, 16'h0008);
        rd_reg(`TMCP_ADR_TMR, d);
        `CHK(d[0], 1'b0)
        repeat (65540) @(posedge clk);
        rd_reg(`TMCP_ADR_TMR, d);
        `CHK(d[0], 1'b1)
        close_out();
    end
endmodule
